// ==== pfbo_pkg.sv ====
// pfbo_pkg: constants and types for the parallel flash bus-operation host controller.
// assumes a 20 MHz clock; all pin timing is expressed as whole clock cycles.
package pfbo_pkg;
    // ==========================================================
    // clock and timing
    localparam int CLK_PERIOD_NS         = 50;
    localparam int ACCESS_TIME_NS        = 90;   // access_time, slowest speed grade
    localparam int RESET_PULSE_MIN_NS    = 500;  // reset_pulse_min, plain default
    localparam int POST_RELEASE_WAIT_NS  = 50;   // post_release_wait, plain default
    localparam int WRITE_PULSE_NS        = 50;
    // least times round up
    localparam int ACCESS_CYC   = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_CYC    = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_CYC  = (POST_RELEASE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WPULSE_CYC   = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W        = 8;
    // ==========================================================
    // pin widths
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    // in-system protect address pattern bits
    localparam int PROT_A6_POS = 6;
    localparam int PROT_A1_POS = 1;
    localparam int PROT_A0_POS = 0;
    // ==========================================================
    // user commands
    typedef enum logic [2:0] {
        PFBO_CMD_READ,
        PFBO_CMD_WRITE,
        PFBO_CMD_RESET,
        PFBO_CMD_PROTECT
    } pfbo_cmd_t;
endpackage : pfbo_pkg

// ==== pfbo_sync_if.sv ====
// pfbo_sync_if: carries synchronised device pins from the synchroniser to the controller.
// assumes both ends run on the same clk.
`timescale 1ns/1ps
`default_nettype none
interface pfbo_sync_if;
    logic [pfbo_pkg::DATA_W-1:0] dq_s;
    logic                        done_pending_flag_s;
    modport src (output dq_s, output done_pending_flag_s);
    modport dst (input dq_s, input done_pending_flag_s);
endinterface : pfbo_sync_if
`default_nettype wire

// ==== pfbo_sync.sv ====
// pfbo_sync: two-flop synchronisers for the pins driven by the flash.
// assumes inputs are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module pfbo_sync (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        resetn,
    // raw pins
    input  wire logic [pfbo_pkg::DATA_W-1:0] dq_in,
    input  wire logic                        done_pending_flag,
    // synchronised side
    pfbo_sync_if.src                         sy
);
    import pfbo_pkg::*;
    logic [DATA_W:0] meta_q, meta_d, stab_q, stab_d;
    // ==========================================================
    // first stage feeds only the second
    always_comb begin
        meta_d = {done_pending_flag, dq_in};
        stab_d = meta_q;
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            // flag bit idles high (ready); a low reset value would fake a busy pulse
            meta_q <= {1'b1, {DATA_W{1'b0}}};
            stab_q <= {1'b1, {DATA_W{1'b0}}};
        end else begin
            meta_q <= meta_d;
            stab_q <= stab_d;
        end
    end
    assign sy.dq_s                = stab_q[DATA_W-1:0];
    assign sy.done_pending_flag_s = stab_q[DATA_W];
endmodule : pfbo_sync
`default_nettype wire

// ==== pfbo_host.sv ====
// pfbo_host: host-side bus controller that drives a parallel NOR flash over its pins.
// assumes a 20 MHz clk; the flash is asynchronous, so returned pins are synchronised.
`timescale 1ns/1ps
`default_nettype none
// Function
// - read: select and gate low, strobe high
// - write: strobe and select low, gate high
// - normal program is four write cycles; here the user issues each cycle, the host drives one write cycle per request
// - bypass program is two write cycles; here the user issues each cycle, the host drives one write cycle per request
// - host waits recovery after reset release
// - protect: elevated reset, A6=0 A1=1 A0=0
// - host verifies after protecting sector; here the user issues the verify read, the host does not
module pfbo_host (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        resetn,
    // user request
    input  wire logic                        req_valid,
    input  var  pfbo_pkg::pfbo_cmd_t         req_cmd,
    input  wire logic [pfbo_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [pfbo_pkg::DATA_W-1:0] req_wdata,
    input  wire logic                        req_byte_mode,
    // user answer
    output logic                             req_ready,
    output logic                             rsp_valid,
    output logic [pfbo_pkg::DATA_W-1:0]      rsp_rdata,
    output logic                             flash_busy,
    // flash pins
    output logic [pfbo_pkg::ADDR_W-1:0]      addr,
    output logic [pfbo_pkg::DATA_W-1:0]      dq_out,
    output logic [pfbo_pkg::DATA_W-1:0]      dq_oe,
    input  wire logic [pfbo_pkg::DATA_W-1:0] dq_in,
    output logic                             chip_sel_n,
    output logic                             out_gate_n,
    output logic                             wr_strobe_n,
    output logic                             reset_pin_n,
    output logic                             elevated_voltage_level,
    output logic                             width_sel,
    input  wire logic                        done_pending_flag
);
    import pfbo_pkg::*;

    typedef enum logic [2:0] {
        PFBO_RECOVER, PFBO_IDLE, PFBO_RD, PFBO_WR, PFBO_WR_GAP, PFBO_RST, PFBO_DONE
    } pfbo_state_t;

    pfbo_sync_if sy ();

    pfbo_state_t             st_q, st_d;
    logic [CNT_W-1:0]        cnt_q, cnt_d;
    logic [ADDR_W-1:0]       addr_q, addr_d;
    logic [DATA_W-1:0]       dqo_q, dqo_d, dqe_q, dqe_d, rdat_q, rdat_d;
    logic                    ce_q, ce_d, oe_q, oe_d, we_q, we_d, rp_q, rp_d;
    logic                    vid_q, vid_d, byte_q, byte_d;
    logic                    rdy_q, rdy_d, rv_q, rv_d, busy_q, busy_d;

    // ==========================================================
    // pin synchronisers
    pfbo_sync u_sync (
        .clk               (clk),
        .resetn            (resetn),
        .dq_in             (dq_in),
        .done_pending_flag (done_pending_flag),
        .sy                (sy)
    );

    // ==========================================================
    // bus cycle sequencer
    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        addr_d = addr_q;
        dqo_d  = dqo_q;
        dqe_d  = dqe_q;
        rdat_d = rdat_q;
        ce_d   = ce_q;
        oe_d   = oe_q;
        we_d   = we_q;
        rp_d   = rp_q;
        vid_d  = vid_q;
        byte_d = byte_q;
        rdy_d  = 1'b0;
        rv_d   = 1'b0;
        busy_d = ~sy.done_pending_flag_s; // low flag means busy, also during reset
        case (st_q)
            // wait out recovery before any cycle
            PFBO_RECOVER: begin
                if (cnt_q >= CNT_W'(RECOVER_CYC)) begin
                    st_d  = PFBO_IDLE;
                    rdy_d = 1'b1;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            PFBO_IDLE: begin
                rdy_d = 1'b1;
                vid_d = 1'b0;
                if (req_valid && rdy_q) begin
                    rdy_d  = 1'b0;
                    cnt_d  = '0;
                    byte_d = ~req_byte_mode; // width pin high = word
                    addr_d = req_addr;
                    // byte mode: line 15 carries the low address bit
                    dqo_d  = req_wdata;
                    case (req_cmd)
                        PFBO_CMD_READ: begin
                            st_d  = PFBO_RD;
                            ce_d  = 1'b0; // select and gate low, strobe high
                            oe_d  = 1'b0;
                            we_d  = 1'b1;
                            dqe_d = req_byte_mode ? {1'b1, 15'h0000} : 16'h0000;
                        end
                        PFBO_CMD_WRITE, PFBO_CMD_PROTECT: begin
                            // command cycles are issued one by one by the user
                            // protect-verify is a later read that the user issues
                            st_d  = PFBO_WR;
                            ce_d  = 1'b0; // select and strobe low, gate high
                            oe_d  = 1'b1;
                            we_d  = 1'b0;
                            dqe_d = req_byte_mode ? {1'b1, 7'h00, 8'hFF} : 16'hFFFF;
                            if (req_cmd == PFBO_CMD_PROTECT) begin
                                vid_d = 1'b1; // elevated reset level
                                addr_d[PROT_A6_POS] = 1'b0;
                                addr_d[PROT_A1_POS] = 1'b1;
                                addr_d[PROT_A0_POS] = 1'b0;
                            end
                        end
                        default: begin
                            st_d = PFBO_RST;
                            rp_d = 1'b0; // hardware reset pulse
                            ce_d = 1'b1;
                            oe_d = 1'b1;
                            we_d = 1'b1;
                            dqe_d = '0;
                        end
                    endcase
                end
            end
            PFBO_RD: begin
                if (cnt_q >= CNT_W'(ACCESS_CYC + 2)) begin // access plus sync delay
                    rdat_d = req_byte_mode_hold(sy.dq_s, byte_q);
                    ce_d   = 1'b1;
                    oe_d   = 1'b1;
                    dqe_d  = '0;
                    st_d   = PFBO_DONE;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            PFBO_WR: begin
                if (cnt_q >= CNT_W'(WPULSE_CYC)) begin
                    we_d  = 1'b1; // rising strobe latches the data
                    cnt_d = '0;
                    st_d  = PFBO_WR_GAP;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            PFBO_WR_GAP: begin
                ce_d  = 1'b1;
                dqe_d = '0;
                vid_d = 1'b0;
                st_d  = PFBO_DONE;
            end
            PFBO_RST: begin
                if (cnt_q >= CNT_W'(RESET_CYC)) begin
                    rp_d  = 1'b1;
                    cnt_d = '0;
                    st_d  = PFBO_RECOVER; // device back in read array
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            default: begin // PFBO_DONE
                rv_d  = 1'b1;
                rdy_d = 1'b1;
                st_d  = PFBO_IDLE;
            end
        endcase
    end

    // low eight lines only in byte mode; identification reads use them too
    function automatic logic [DATA_W-1:0] req_byte_mode_hold(
        input logic [DATA_W-1:0] d, input logic word_mode);
        req_byte_mode_hold = word_mode ? d : {8'h00, d[7:0]};
    endfunction : req_byte_mode_hold

    // ==========================================================
    // registers; pins idle deselected and reset released
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_q   <= PFBO_RECOVER;
            cnt_q  <= '0;
            addr_q <= '0;
            dqo_q  <= '0;
            dqe_q  <= '0;
            rdat_q <= '0;
            ce_q   <= 1'b1;
            oe_q   <= 1'b1;
            we_q   <= 1'b1;
            rp_q   <= 1'b1;
            vid_q  <= 1'b0;
            byte_q <= 1'b1;
            rdy_q  <= 1'b0;
            rv_q   <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            addr_q <= addr_d;
            dqo_q  <= dqo_d;
            dqe_q  <= dqe_d;
            rdat_q <= rdat_d;
            ce_q   <= ce_d;
            oe_q   <= oe_d;
            we_q   <= we_d;
            rp_q   <= rp_d;
            vid_q  <= vid_d;
            byte_q <= byte_d;
            rdy_q  <= rdy_d;
            rv_q   <= rv_d;
            busy_q <= busy_d;
        end
    end

    // outputs straight from flops
    assign addr                   = addr_q;
    assign dq_out                 = dqo_q;
    assign dq_oe                  = dqe_q;
    assign chip_sel_n             = ce_q;
    assign out_gate_n             = oe_q;
    assign wr_strobe_n            = we_q;
    assign reset_pin_n            = rp_q;
    assign elevated_voltage_level = vid_q;
    assign width_sel              = byte_q;
    assign req_ready              = rdy_q;
    assign rsp_valid              = rv_q;
    assign rsp_rdata              = rdat_q;
    assign flash_busy             = busy_q;
endmodule : pfbo_host
`default_nettype wire

// ==== pfbo_host_sva.sv ====
// pfbo_host_sva: pin and handshake checks for the flash host controller.
// assumes one clk domain and the synchronous active-low resetn.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// checker
module pfbo_chk
    import pfbo_pkg::*;
(
    // clock and reset
    input wire logic                        clk,
    input wire logic                        resetn,
    // user side
    input wire logic                        req_valid,
    input var  pfbo_pkg::pfbo_cmd_t         req_cmd,
    input wire logic                        req_ready,
    input wire logic                        rsp_valid,
    input wire logic                        flash_busy,
    // flash pins
    input wire logic [pfbo_pkg::ADDR_W-1:0] addr,
    input wire logic [pfbo_pkg::DATA_W-1:0] dq_oe,
    input wire logic                        chip_sel_n,
    input wire logic                        out_gate_n,
    input wire logic                        wr_strobe_n,
    input wire logic                        reset_pin_n,
    input wire logic                        elevated_voltage_level,
    input wire logic                        done_pending_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // a request is taken on this edge
    wire take = req_valid && req_ready;
    // read: select and gate low five cycles, then gate released
    sequence s_rd_gate;
        (!chip_sel_n && !out_gate_n)[*5] ##1 out_gate_n;
    endsequence
    // write: strobe low two cycles inside select, then select released
    sequence s_wr_pulse;
        (!wr_strobe_n && !chip_sel_n)[*2] ##1 (wr_strobe_n && !chip_sel_n) ##1 chip_sel_n;
    endsequence
    rd_walk_a: assert property (
        take && req_cmd == PFBO_CMD_READ |=> s_rd_gate) else $error("read pulse wrong");
    rd_done_a: assert property (
        take && req_cmd == PFBO_CMD_READ |-> ##7 rsp_valid) else $error("read late");
    wr_walk_a: assert property (
        take && req_cmd inside {PFBO_CMD_WRITE, PFBO_CMD_PROTECT} |=> s_wr_pulse)
        else $error("write pulse wrong");
    wr_done_a: assert property (
        take && req_cmd == PFBO_CMD_WRITE |-> ##5 rsp_valid) else $error("write late");
    wr_legal_a: assert property (
        !wr_strobe_n |-> !chip_sel_n && out_gate_n) else $error("illegal write");
    rd_legal_a: assert property (
        !out_gate_n |-> wr_strobe_n && dq_oe[14:0] == 15'h0000) else $error("bus clash");
    prot_addr_a: assert property (
        elevated_voltage_level && !chip_sel_n |-> !addr[6] && addr[1] && !addr[0])
        else $error("protect address wrong");
    rst_hold_a: assert property (
        $fell(reset_pin_n) |-> (!reset_pin_n)[*8]) else $error("reset pulse short");
    busy_seen_a: assert property (
        (!done_pending_flag)[*5] |-> flash_busy) else $error("busy missed");
    busy_clear_a: assert property (
        done_pending_flag[*5] |-> !flash_busy) else $error("busy stuck");
endmodule : pfbo_chk
bind pfbo_host pfbo_chk chk_u (.clk, .resetn, .req_valid, .req_cmd, .req_ready, .rsp_valid,
    .flash_busy, .addr, .dq_oe, .chip_sel_n, .out_gate_n, .wr_strobe_n, .reset_pin_n,
    .elevated_voltage_level, .done_pending_flag);
`default_nettype wire

// ==== pfbo_flash_model.sv ====
// pfbo_flash_model: behavioural flash, 64 words in 4-word sectors.
// assumes the bench resolves dq from both drivers.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// model
module pfbo_flash_model #(
    parameter int ACC_NS  = 90,  // access_time
    parameter int PROG_NS = 800,
    parameter int RDY_NS  = 500
) (
    // host pins
    input wire logic [pfbo_pkg::ADDR_W-1:0] addr,
    input wire logic [pfbo_pkg::DATA_W-1:0] dq,
    input wire logic                        chip_sel_n,
    input wire logic                        out_gate_n,
    input wire logic                        wr_strobe_n,
    input wire logic                        reset_pin_n,
    input wire logic                        elevated_voltage_level,
    input wire logic                        width_sel,
    // device outputs
    output logic [pfbo_pkg::DATA_W-1:0]     fdq,
    output var logic                        rdy
);
    logic [15:0] mem [64]; // scaled stand-in for the boot and main sectors
    logic        prot [16];
    logic [15:0] last_q;
    logic [15:0] rd_d;
    time         busy_end;
    wire rd_en = !chip_sel_n && !out_gate_n && wr_strobe_n && reset_pin_n;
    // power-up contents readable at once
    initial begin
        rdy = 1'b1;
        busy_end = 0;
        last_q = 16'h0000;
        for (int i = 0; i < 64; i++) mem[i] = 16'hA500 | 16'(i);
        for (int i = 0; i < 16; i++) prot[i] = 1'b0;
    end
    // sleep on a stable address is invisible here: data stays valid
    assign #(ACC_NS) rd_d = mem[addr[5:0]];
    always @(rd_d or rd_en) if (rd_en) last_q = rd_d;
    // released lines show inverted data so a stale sample cannot pass
    // byte mode: line 15 is the low address bit and picks the byte
    wire hi_byte = !width_sel && dq[15];
    assign fdq[7:0]  = !rd_en ? ~last_q[7:0] : hi_byte ? rd_d[15:8] : rd_d[7:0];
    assign fdq[15:8] = rd_en && width_sel ? rd_d[15:8] : ~last_q[15:8];
    // writes commit on the rising strobe
    always @(posedge wr_strobe_n) begin
        if (!chip_sel_n && out_gate_n) begin
            if (elevated_voltage_level) prot[addr[5:2]] = 1'b1;
            else if (reset_pin_n && !prot[addr[5:2]]) begin
                mem[addr[5:0]] = dq;
                rdy = 1'b0;
                busy_end = $time + PROG_NS; // deselect does not cut it
            end
        end
    end
    // a reset during a program holds busy until the internal reset ends
    always @(negedge reset_pin_n) if (!rdy) busy_end = $time + RDY_NS;
    // nonblocking release so the host's flops never race it
    always #5 if (!rdy && $time >= busy_end) rdy <= 1'b1;
endmodule : pfbo_flash_model
`default_nettype wire

// ==== pfbo_host_tb.sv ====
// pfbo_host_tb: self-checking bench for the flash host controller.
// assumes pfbo_flash_model on the pins and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module pfbo_host_tb;
    import pfbo_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, req_valid = 1'b0, req_byte_mode = 1'b0;
    pfbo_cmd_t req_cmd = PFBO_CMD_READ;
    logic [ADDR_W-1:0] req_addr = 20'h00000, addr;
    logic [DATA_W-1:0] req_wdata = 16'h0000, rsp_rdata, dq_out, dq_oe, dq_in, fdq, q;
    logic req_ready, rsp_valid, flash_busy, chip_sel_n, out_gate_n, wr_strobe_n;
    logic reset_pin_n, elevated_voltage_level, width_sel, done_pending_flag;
    int fail_count = 0, comparisons = 0, cycles = 0;
    always #25 clk = ~clk;
    // host lines win where enabled
    assign dq_in = (dq_oe & dq_out) | (~dq_oe & fdq);
    pfbo_host dut_u (.clk, .resetn, .req_valid, .req_cmd, .req_addr, .req_wdata,
        .req_byte_mode, .req_ready, .rsp_valid, .rsp_rdata, .flash_busy, .addr, .dq_out,
        .dq_oe, .dq_in, .chip_sel_n, .out_gate_n, .wr_strobe_n, .reset_pin_n,
        .elevated_voltage_level, .width_sel, .done_pending_flag);
    pfbo_flash_model flash_u (.addr, .dq(dq_in), .chip_sel_n, .out_gate_n, .wr_strobe_n,
        .reset_pin_n, .elevated_voltage_level, .width_sel, .fdq, .rdy(done_pending_flag));
    // ==========================================================
    // verdict and hang guard
    task automatic results;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            results();
        end
    end
    // one transfer: hold request until taken, then await the answer
    task automatic xfer(input pfbo_cmd_t c, input logic [19:0] a, input logic [15:0] d);
        int n;
        req_cmd <= c;
        req_addr <= a;
        req_wdata <= d;
        req_valid <= 1'b1;
        do @(posedge clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        // a reset answers only by raising req_ready after recovery
        end while (rsp_valid !== 1'b1 && !(c == PFBO_CMD_RESET && req_ready === 1'b1)
                   && n < 80);
        `CHK(n < 80, 1'b1)
        q = rsp_rdata;
    endtask : xfer
    // ==========================================================
    // scenarios
    task automatic t_boot;
        xfer(PFBO_CMD_READ, 20'h00003, 16'h0000);
        `CHK(q, 16'hA503)
    endtask : t_boot
    task automatic t_wr_rd;
        xfer(PFBO_CMD_WRITE, 20'h00005, 16'h3C5A);
        xfer(PFBO_CMD_READ, 20'h00005, 16'h0000);
        `CHK(q, 16'h3C5A)
        xfer(PFBO_CMD_READ, 20'h00006, 16'h0000);
        `CHK(q, 16'hA506)
    endtask : t_wr_rd
    // sector 2 locked, sector 3 still open
    task automatic t_prot;
        xfer(PFBO_CMD_PROTECT, 20'h00009, 16'h0000);
        xfer(PFBO_CMD_WRITE, 20'h00009, 16'h1234);
        xfer(PFBO_CMD_READ, 20'h00009, 16'h0000);
        `CHK(q, 16'hA509)
        xfer(PFBO_CMD_WRITE, 20'h0000D, 16'h0F0F);
        xfer(PFBO_CMD_READ, 20'h0000D, 16'h0000);
        `CHK(q, 16'h0F0F)
    endtask : t_prot
    // byte mode: line 15 carries the low address bit
    task automatic t_byte;
        req_byte_mode <= 1'b1;
        xfer(PFBO_CMD_READ, 20'h00003, 16'h8000);
        `CHK(q, 16'h00A5)
        xfer(PFBO_CMD_READ, 20'h00003, 16'h0000);
        `CHK(q, 16'h0003)
        req_byte_mode <= 1'b0;
    endtask : t_byte
    // reset lands while the program is still busy
    task automatic t_rst;
        xfer(PFBO_CMD_WRITE, 20'h00014, 16'h5AA5);
        repeat (3) @(posedge clk);
        `CHK(flash_busy, 1'b1)
        xfer(PFBO_CMD_RESET, 20'h00000, 16'h0000);
        `CHK(reset_pin_n, 1'b1)
        `CHK(flash_busy, 1'b0)
        // the cut program's word is undefined, so read an untouched one
        xfer(PFBO_CMD_READ, 20'h00015, 16'h0000);
        `CHK(q, 16'hA515)
    endtask : t_rst
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        t_boot();
        t_wr_rd();
        t_prot();
        t_byte();
        t_rst();
        results();
    end
endmodule : pfbo_host_tb
`default_nettype wire
